// *** core/option_byte_config_decoder.sv ***
// Purpose: Latch and decode the two static option bytes into device settings
// Assumes: Option store bytes are static while the device runs
// Notes:   Bytes are not bus visible; only decoded settings can be read
// Functional notes
// - Blank store decodes to default settings
// - Option bytes absent from processor memory map
// - Halt with watchdog active may reset
// - Watchdog hardware or software type select
// - Voltage detection field selects threshold
// - Clear bit enables read-out protection
// - Protected option erase wipes user memory first
// - Package pair selects 80 or 64 pins
// - Unbonded pads pulled-up inputs from first clock after reset release; reset value 8'h00
// - Reset phase length 4096 or 256
// - Clock source field decode
// - Range field selects drive or band
// - Clear bit enables clock doubler
// - ROM variants use fixed option values
`timescale 1ns/1ps
`include "option_config_defines.svh"
module option_byte_config_decoder #(
  parameter logic       ROM_VARIANT = 1'b0,
  parameter logic [7:0] ROM_BYTE0   = 8'hFF,
  parameter logic [7:0] ROM_BYTE1   = 8'hFF
) (
  input  wire logic                           clk,
  input  wire logic                           nrst,
  input  wire logic                           hsel,
  input  wire logic [31:0]                    haddr,
  input  wire logic [1:0]                     htrans,
  input  wire logic                           hwrite,
  input  wire logic [2:0]                     hsize,
  input  wire logic [31:0]                    hwdata,
  input  wire logic                           hready,
  output logic                                hreadyout,
  output logic                                hresp,
  output logic [31:0]                         hrdata,
  input  wire logic [7:0]                     store_byte0,
  input  wire logic [7:0]                     store_byte1,
  input  wire logic                           halt_entry,
  input  wire logic                           halt_exit,
  input  wire logic                           erase_req_pin,
  input  wire logic                           user_erase_done,
  output logic                                watchdog_enable,
  output logic                                halt_reset_req,
  output logic                                low_supply_detector_en,
  output logic                                auxiliary_supply_detector_en,
  output option_config_pkg::voltage_level_t   voltage_detect_sel,
  output logic                                readout_protect_en,
  output logic                                package_80pin,
  output logic [7:0]                          unbonded_pad_pullup,
  output logic                                reset_phase_active,
  output option_config_pkg::clock_source_t    clock_source_sel,
  output logic [2:0]                          osc_range_sel,
  output logic                                clock_doubler_en,
  output logic                                user_mem_erase,
  output logic                                opt_erase_grant
);
  logic                        rst_meta;
  logic                        rst_n;
  logic [7:0]                  b0;
  logic [7:0]                  b1;
  logic [7:0]                  next_b0;
  logic [7:0]                  next_b1;
  option_config_pkg::phase_t   phase;
  option_config_pkg::phase_t   next_phase;
  logic [`CNT_W-1:0]           cnt;
  logic [`CNT_W-1:0]           next_cnt;
  logic [`CNT_W-1:0]           len;
  logic [`CNT_W-1:0]           src_len;
  option_config_pkg::erase_t   er_state;
  option_config_pkg::erase_t   next_er_state;
  logic                        erase_level;
  logic                        erase_level_d;
  logic                        erase_rise;
  logic                        sw_wdg_start;
  logic                        next_sw_wdg_start;
  logic                        wr_pend;
  logic [7:0]                  wr_addr;
  logic                        next_wr_pend;
  logic [7:0]                  next_wr_addr;
  logic [31:0]                 next_hrdata;
  logic                        addr_take;
  logic                        cfg_unsupported;
  logic [7:0]                  src0;
  logic [7:0]                  src1;

  // Internal reset copy: async assert, two-stage release
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  pin_sync erase_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .pin   (erase_req_pin),
    .level (erase_level)
  );

  assign src0 = ROM_VARIANT ? ROM_BYTE0 : store_byte0;
  assign src1 = ROM_VARIANT ? ROM_BYTE1 : store_byte1;
  assign len  = b1[`B1_RST_LEN] ? `RST_SHORT_CYCLES : `RST_LONG_CYCLES;
  assign src_len = src1[`B1_RST_LEN] ? `RST_SHORT_CYCLES : `RST_LONG_CYCLES;
  assign erase_rise = erase_level && !erase_level_d;
  assign addr_take  = hsel && htrans[1] && hready;

  // Load and reset-phase sequencing
  always_comb begin
    next_b0    = b0;
    next_b1    = b1;
    next_phase = phase;
    next_cnt   = cnt;
    unique case (phase)
      option_config_pkg::PH_LOAD: begin
        // Captured once; store changes later are ignored until next reset
        next_b0    = src0;
        next_b1    = src1;
        next_phase = option_config_pkg::PH_COUNT;
        next_cnt   = src_len - `CNT_W'(1);
      end
      option_config_pkg::PH_COUNT: begin
        if (cnt == '0) begin
          next_phase = option_config_pkg::PH_RUN;
        end else begin
          next_cnt = cnt - `CNT_W'(1);
        end
      end
      option_config_pkg::PH_RUN: begin
        if (halt_exit) begin
          next_phase = option_config_pkg::PH_COUNT;
          next_cnt   = len - `CNT_W'(1);
        end
      end
    endcase
  end

  // Protected option erase wipes user memory before granting
  always_comb begin
    next_er_state = er_state;
    unique case (er_state)
      option_config_pkg::ER_IDLE: begin
        if (erase_rise && phase == option_config_pkg::PH_RUN) begin
          next_er_state = readout_protect_en ? option_config_pkg::ER_USER
                                             : option_config_pkg::ER_GRANT;
        end
      end
      option_config_pkg::ER_USER: begin
        if (user_erase_done) begin
          next_er_state = option_config_pkg::ER_GRANT;
        end
      end
      option_config_pkg::ER_GRANT: begin
        next_er_state = option_config_pkg::ER_IDLE;
      end
    endcase
  end

  // Only decoded settings are readable; raw bytes have no address
  always_comb begin
    next_hrdata       = hrdata;
    next_wr_pend      = addr_take && hwrite;
    next_wr_addr      = addr_take ? haddr[7:0] : wr_addr;
    next_sw_wdg_start = sw_wdg_start;
    // Software start is one-way: cannot stop the watchdog once running
    if (wr_pend && wr_addr == `ADDR_CTRL && hwdata[`CTRL_WDG_START]) begin
      next_sw_wdg_start = 1'b1;
    end
    if (addr_take && !hwrite) begin
      unique case (haddr[7:0])
        `ADDR_SETTINGS0: next_hrdata = {24'h000000, b0[`B0_HALT_RST],
                                        !b0[`B0_WDG_TYPE], 2'(voltage_detect_sel),
                                        auxiliary_supply_detector_en,
                                        low_supply_detector_en, package_80pin,
                                        readout_protect_en};
        `ADDR_SETTINGS1: next_hrdata = {25'h0000000, !b1[`B1_RST_LEN], clock_doubler_en,
                                        osc_range_sel, 2'(clock_source_sel)};
        `ADDR_CTRL:      next_hrdata = {31'h00000000, sw_wdg_start};
        `ADDR_STATE:     next_hrdata = {28'h0000000, cfg_unsupported, watchdog_enable,
                                        user_mem_erase, reset_phase_active};
        default:         next_hrdata = 32'h00000000;
      endcase
    end
  end

  // Reset values equal a blank store so defaults show from reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      b0            <= `OPT_BLANK;
      b1            <= `OPT_BLANK;
      phase         <= option_config_pkg::PH_LOAD;
      cnt           <= '0;
      er_state      <= option_config_pkg::ER_IDLE;
      erase_level_d <= 1'b0;
      sw_wdg_start  <= 1'b0;
      wr_pend       <= 1'b0;
      wr_addr       <= 8'h00;
      hrdata        <= 32'h00000000;
    end else begin
      b0            <= next_b0;
      b1            <= next_b1;
      phase         <= next_phase;
      cnt           <= next_cnt;
      er_state      <= next_er_state;
      erase_level_d <= erase_level;
      sw_wdg_start  <= next_sw_wdg_start;
      wr_pend       <= next_wr_pend;
      wr_addr       <= next_wr_addr;
      hrdata        <= next_hrdata;
    end
  end

  option_config_pkg::voltage_level_t next_vd;
  option_config_pkg::clock_source_t  next_clk;
  always_comb begin
    next_vd = option_config_pkg::VD_HIGHEST;
    unique case (next_b0[`B0_VD_HI:`B0_VD_LO])
      `VD_CODE_OFF: next_vd = option_config_pkg::VD_OFF;
      `VD_CODE_LOW: next_vd = option_config_pkg::VD_LOWEST;
      `VD_CODE_MED: next_vd = option_config_pkg::VD_MEDIUM;
      default:      next_vd = option_config_pkg::VD_HIGHEST;
    endcase
    unique case (next_b1[`B1_CLK_HI:`B1_CLK_LO])
      2'h0:    next_clk = option_config_pkg::CLK_RESONATOR;
      2'h1:    next_clk = option_config_pkg::CLK_RESERVED;
      2'h2:    next_clk = option_config_pkg::CLK_INTERNAL_RC;
      default: next_clk = option_config_pkg::CLK_EXTERNAL;
    endcase
  end

  logic next_pkg80;
  assign next_pkg80 = next_b1[`B1_PKG_HI] && next_b0[`B0_PKG_LO];

  // Decoded outputs registered from the next byte values
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout                    <= 1'b1;
      hresp                        <= 1'b0;
      watchdog_enable              <= 1'b0;
      halt_reset_req               <= 1'b0;
      low_supply_detector_en       <= 1'b0;
      auxiliary_supply_detector_en <= 1'b0;
      voltage_detect_sel           <= option_config_pkg::VD_OFF;
      readout_protect_en           <= 1'b0;
      package_80pin                <= 1'b1;
      unbonded_pad_pullup          <= 8'h00;
      reset_phase_active           <= 1'b1;
      clock_source_sel             <= option_config_pkg::CLK_EXTERNAL;
      osc_range_sel                <= 3'h7;
      clock_doubler_en             <= 1'b0;
      user_mem_erase               <= 1'b0;
      opt_erase_grant              <= 1'b0;
      cfg_unsupported              <= 1'b0;
    end else begin
      hreadyout                    <= 1'b1;
      hresp                        <= 1'b0;
      watchdog_enable              <= !next_b0[`B0_WDG_TYPE] || next_sw_wdg_start;
      halt_reset_req               <= halt_entry && watchdog_enable
                                      && b0[`B0_HALT_RST];
      low_supply_detector_en       <= next_vd != option_config_pkg::VD_OFF;
      auxiliary_supply_detector_en <= next_vd != option_config_pkg::VD_OFF;
      voltage_detect_sel           <= next_vd;
      readout_protect_en           <= !next_b0[`B0_RDP];
      package_80pin                <= next_pkg80;
      // Unbonded pads forced to pulled-up inputs from the first clock after reset release; reset value is 8'h00
      unbonded_pad_pullup          <= next_pkg80 ? 8'h00 : `PAD_UNBONDED_64;
      reset_phase_active           <= next_phase != option_config_pkg::PH_RUN;
      clock_source_sel             <= next_clk;
      osc_range_sel                <= next_b1[`B1_RANGE_HI:`B1_RANGE_LO];
      clock_doubler_en             <= !next_b1[`B1_DBL_OFF];
      user_mem_erase               <= next_er_state == option_config_pkg::ER_USER;
      opt_erase_grant              <= next_er_state == option_config_pkg::ER_GRANT;
      // Flags combinations the tool should not program; decode still honours them
      cfg_unsupported              <= (!next_b1[`B1_DBL_OFF]
                                      && (next_clk != option_config_pkg::CLK_RESONATOR
                                      || next_b1[`B1_RANGE_HI:`B1_RANGE_LO] != `RANGE_DBL_OK))
                                      || (!next_b0[`B0_RDP] && next_vd != option_config_pkg::VD_OFF);
    end
  end

  // Helper: cycles spent counting the reset phase
  logic [`CNT_W-1:0] meas;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meas <= '0;
    end else begin
      meas <= (phase == option_config_pkg::PH_COUNT) ? meas + `CNT_W'(1) : '0;
    end
  end

  sequence s_erase_start;
    er_state == option_config_pkg::ER_IDLE && erase_rise
      && phase == option_config_pkg::PH_RUN && readout_protect_en;
  endsequence

  sequence s_user_wipe;
    user_mem_erase && !opt_erase_grant;
  endsequence

  sequence s_wipe_done;
    user_mem_erase && user_erase_done;
  endsequence

  a_reset_len_count: assert property (@(posedge clk) disable iff (!rst_n)
    (phase == option_config_pkg::PH_COUNT && next_phase == option_config_pkg::PH_RUN)
      |-> (meas + `CNT_W'(1) == len))
    else $error("reset phase length wrong");

  a_halt_wdg_reset: assert property (@(posedge clk) disable iff (!rst_n)
    halt_entry |=> (halt_reset_req == ($past(watchdog_enable) && $past(b0[`B0_HALT_RST]))))
    else $error("halt reset decision wrong");

  a_wdg_hw_on: assert property (@(posedge clk) disable iff (!rst_n)
    (phase == option_config_pkg::PH_RUN && !b0[`B0_WDG_TYPE]) |-> watchdog_enable)
    else $error("hardware watchdog not enabled");

  a_watchdog_type_sel_off: assert property (@(posedge clk) disable iff (!rst_n)
    (phase == option_config_pkg::PH_RUN && b0[`B0_WDG_TYPE] && !sw_wdg_start)
      |-> !watchdog_enable)
    else $error("software watchdog on without start");

  a_vd_detect_off: assert property (@(posedge clk) disable iff (!rst_n)
    phase == option_config_pkg::PH_RUN
      |-> (low_supply_detector_en == (b0[`B0_VD_HI:`B0_VD_LO] != `VD_CODE_OFF)))
    else $error("voltage detector enable wrong");

  a_protect_bit: assert property (@(posedge clk) disable iff (!rst_n)
    phase == option_config_pkg::PH_RUN |-> readout_protect_en == !b0[`B0_RDP])
    else $error("protection decode wrong");

  a_erase_wipe_first: assert property (@(posedge clk) disable iff (!rst_n)
    s_erase_start |=> s_user_wipe)
    else $error("user memory not wiped before option erase");

  a_erase_grant_after: assert property (@(posedge clk) disable iff (!rst_n)
    s_wipe_done |=> (opt_erase_grant && !user_mem_erase))
    else $error("option erase not granted after wipe");

  a_package_pair: assert property (@(posedge clk) disable iff (!rst_n)
    phase == option_config_pkg::PH_RUN
      |-> package_80pin == (b1[`B1_PKG_HI] && b0[`B0_PKG_LO]))
    else $error("package decode wrong");

  a_doubler_range: assert property (@(posedge clk) disable iff (!rst_n)
    phase == option_config_pkg::PH_RUN
      |-> (clock_doubler_en == !b1[`B1_DBL_OFF])
          && (osc_range_sel == b1[`B1_RANGE_HI:`B1_RANGE_LO]))
    else $error("clock decode wrong");

  a_bytes_held: assert property (@(posedge clk) disable iff (!rst_n)
    phase != option_config_pkg::PH_LOAD |=> $stable(b0) && $stable(b1))
    else $error("option bytes changed after load");

  a_rom_fixed: assert property (@(posedge clk) disable iff (!rst_n)
    (ROM_VARIANT && phase == option_config_pkg::PH_RUN)
      |-> (b0 == ROM_BYTE0 && b1 == ROM_BYTE1))
    else $error("ROM variant not using fixed values");
endmodule // option_byte_config_decoder

// *** core/option_config_defines.svh ***
// Purpose: Named offsets, bit positions, reset values and counts of the option decoder
// Assumes: Included by bare name; definitions only
// Notes:   Byte addresses are those of the register slave on the bus
`ifndef OPTION_CONFIG_DEFINES_SVH
`define OPTION_CONFIG_DEFINES_SVH

`define OPT_BLANK          8'hFF
`define B0_HALT_RST        7
`define B0_WDG_TYPE        6
`define B0_VD_HI           4
`define B0_VD_LO           3
`define B0_PKG_LO          1
`define B0_RDP             0
`define B1_PKG_HI          7
`define B1_RST_LEN         6
`define B1_CLK_HI          5
`define B1_CLK_LO          4
`define B1_RANGE_HI        3
`define B1_RANGE_LO        1
`define B1_DBL_OFF         0
`define VD_CODE_OFF        2'h3
`define VD_CODE_LOW        2'h2
`define VD_CODE_MED        2'h1
`define RANGE_DBL_OK       3'h1
`define RST_LONG_CYCLES    13'h1000
`define RST_SHORT_CYCLES   13'h0100
`define CNT_W              13
`define ADDR_SETTINGS0     8'h00
`define ADDR_SETTINGS1     8'h04
`define ADDR_CTRL          8'h08
`define ADDR_STATE         8'h0C
`define CTRL_WDG_START     0
`define PAD_UNBONDED_64    8'hF0

`endif

// *** core/option_config_pkg.sv ***
// Purpose: Types shared by the option decoder files
// Assumes: Used only by package-qualified names
// Notes:   None
package option_config_pkg;

  typedef enum logic [1:0] {
    CLK_RESONATOR,
    CLK_RESERVED,
    CLK_INTERNAL_RC,
    CLK_EXTERNAL
  } clock_source_t;

  typedef enum logic [1:0] {
    VD_OFF,
    VD_LOWEST,
    VD_MEDIUM,
    VD_HIGHEST
  } voltage_level_t;

  typedef enum logic [1:0] {
    PH_LOAD,
    PH_COUNT,
    PH_RUN
  } phase_t;

  typedef enum logic [1:0] {
    ER_IDLE,
    ER_USER,
    ER_GRANT
  } erase_t;

endpackage

// *** core/pin_sync.sv ***
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Input is asynchronous to clk
// Notes:   Output moves only when stages two and three agree
`timescale 1ns/1ps
module pin_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      level
);
  logic s1;
  logic s2;
  logic s3;
  logic next_level;

  always_comb begin
    next_level = (s2 == s3) ? s3 : level;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1    <= 1'b0;
      s2    <= 1'b0;
      s3    <= 1'b0;
      level <= 1'b0;
    end else begin
      s1    <= pin;
      s2    <= s1;
      s3    <= s2;
      level <= next_level;
    end
  end
endmodule // pin_sync

// *** dv/option_byte_config_decoder_tb.sv ***
// Purpose: Self-checking bench for the option byte decoder
// Assumes: Zero-wait bus slave; legal option bytes from the tool model
// Notes:   Each configuration is loaded through a full reset
`timescale 1ns/1ps
`include "option_config_defines.svh"
module option_byte_config_decoder_tb;
  logic        clk, nrst, hsel, hwrite, hreadyout, hresp, halt_entry, halt_exit;
  logic        erase_cmd, erase_req_pin, user_erase_done, watchdog_enable, halt_reset_req;
  logic        low_det, aux_det, readout_protect_en, package_80pin, reset_phase_active;
  logic        clock_doubler_en, user_mem_erase, opt_erase_grant;
  logic [1:0]  htrans;
  logic [2:0]  hsize, osc_range_sel;
  logic [7:0]  want_b0, want_b1, store_b0, store_b1, unbonded_pad_pullup;
  logic [31:0] haddr, hwdata, hrdata, rd;
  option_config_pkg::voltage_level_t vd_sel;
  option_config_pkg::clock_source_t  clk_src;
  int          errors, n_tests, k;
  logic [7:0]  cfg0 [5] = '{8'hFF, 8'h27, 8'hAD, 8'hBE, 8'hF5};
  logic [7:0]  cfg1 [5] = '{8'hFF, 8'h82, 8'hE5, 8'hDD, 8'hB7};

  prog_tool_model tool_u (.clk(clk), .want_byte0(want_b0), .want_byte1(want_b1),
    .erase_cmd(erase_cmd), .store_byte0(store_b0), .store_byte1(store_b1),
    .erase_req_pin(erase_req_pin));
  option_byte_config_decoder dut_u (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .store_byte0(store_b0),
    .store_byte1(store_b1), .halt_entry(halt_entry), .halt_exit(halt_exit),
    .erase_req_pin(erase_req_pin), .user_erase_done(user_erase_done),
    .watchdog_enable(watchdog_enable), .halt_reset_req(halt_reset_req),
    .low_supply_detector_en(low_det), .auxiliary_supply_detector_en(aux_det),
    .voltage_detect_sel(vd_sel), .readout_protect_en(readout_protect_en),
    .package_80pin(package_80pin), .unbonded_pad_pullup(unbonded_pad_pullup),
    .reset_phase_active(reset_phase_active), .clock_source_sel(clk_src),
    .osc_range_sel(osc_range_sel), .clock_doubler_en(clock_doubler_en),
    .user_mem_erase(user_mem_erase), .opt_erase_grant(opt_erase_grant));

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_ready;
    int i;
    i = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      i++;
      if (i > 50) begin
        chk("hready timeout", 1, 0);
        tally_and_finish();
      end
      @(posedge clk);
    end
  endtask

  // Master changes signals only right after an edge; waits for ready each phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    chk("hresp", 0, {31'h0, hresp});
  endtask

  task automatic restart(input logic [7:0] b0, input logic [7:0] b1);
    @(posedge clk);
    nrst    <= 1'b0;
    want_b0 <= b0;
    want_b1 <= b1;
    repeat (8) @(posedge clk);
    nrst    <= 1'b1;
  endtask

  // Counts negedges with the phase flag high; exact count expected
  task automatic phase_len(input int lo, input string what);
    int n;
    n = 0;
    @(negedge clk);
    while (reset_phase_active === 1'b1 && n < 5000) begin
      n++;
      @(negedge clk);
    end
    chk(what, lo, n);
  endtask

  task automatic check_cfg(input logic [7:0] b0, input logic [7:0] b1);
    logic p80;
    logic det;
    p80 = b1[7] & b0[1];
    det = (b0[4:3] != 2'h3);
    chk("watchdog", {31'h0, ~b0[6]}, {31'h0, watchdog_enable});
    chk("vd sel", {30'h0, ~b0[4:3]}, {30'h0, vd_sel});
    chk("detectors", {30'h0, det, det}, {30'h0, low_det, aux_det});
    chk("protect", {31'h0, ~b0[0]}, {31'h0, readout_protect_en});
    chk("package", {31'h0, p80}, {31'h0, package_80pin});
    chk("pad pullup", p80 ? 0 : `PAD_UNBONDED_64, {24'h0, unbonded_pad_pullup});
    chk("clock src", {30'h0, b1[5:4]}, {30'h0, clk_src});
    chk("range", {29'h0, b1[3:1]}, {29'h0, osc_range_sel});
    chk("doubler", {31'h0, ~b1[0]}, {31'h0, clock_doubler_en});
    @(posedge clk);
    bus(1'b0, `ADDR_SETTINGS0, 0);
    chk("settings0", {24'h0, b0[7], ~b0[6], ~b0[4:3], det, det, p80, ~b0[0]}, rd);
    bus(1'b0, `ADDR_SETTINGS1, 0);
    chk("settings1", {25'h0, ~b1[6], ~b1[0], b1[3:1], b1[5:4]}, rd);
  endtask

  task automatic halt_try(input int exp);
    int seen;
    seen = 0;
    @(posedge clk);
    halt_entry <= 1'b1;
    @(posedge clk);
    halt_entry <= 1'b0;
    repeat (4) begin
      @(negedge clk);
      if (halt_reset_req === 1'b1) seen++;
    end
    chk("halt reset pulses", exp, seen);
  endtask

  task automatic erase_try(input logic prot);
    int i;
    @(posedge clk);
    erase_cmd <= 1'b1;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (user_mem_erase !== 1'b1 && opt_erase_grant !== 1'b1 && i < 20);
    chk("user erase", {31'h0, prot}, {31'h0, user_mem_erase});
    chk("grant", {31'h0, ~prot}, {31'h0, opt_erase_grant});
    if (prot) begin
      repeat (5) @(negedge clk);
      chk("erase held", 1, {31'h0, user_mem_erase});
      @(posedge clk);
      user_erase_done <= 1'b1;
      @(posedge clk);
      user_erase_done <= 1'b0;
      @(negedge clk);
      chk("grant after wipe", 2'h1, {30'h0, user_mem_erase, opt_erase_grant});
    end
    @(negedge clk);
    chk("grant width", 0, {31'h0, opt_erase_grant});
    @(posedge clk);
    erase_cmd <= 1'b0;
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    {nrst, hsel, hwrite, halt_entry, halt_exit, erase_cmd, user_erase_done} = 7'h00;
    {htrans, hsize, haddr, hwdata} = {2'h0, 3'h2, 64'h0};
    {want_b0, want_b1} = 16'hFFFF;
    errors = 0;
    n_tests = 0;
    for (k = 0; k < 5; k++) begin
      if (k > 0) begin
        @(posedge clk);
        want_b0 <= cfg0[k];
        want_b1 <= cfg1[k];
        repeat (4) @(posedge clk);
        check_cfg(cfg0[k-1], cfg1[k-1]);
      end
      restart(cfg0[k], cfg1[k]);
      // Count plus the load cycle plus the two-flop reset release
      phase_len(cfg1[k][6] ? 259 : 4099, "reset phase");
      check_cfg(cfg0[k], cfg1[k]);
      case (k)
        0: begin
          bus(1'b0, 8'h10, 0);
          chk("unmapped read", 0, rd);
          bus(1'b1, `ADDR_SETTINGS0, 0);
          check_cfg(cfg0[k], cfg1[k]);
          halt_try(0);
          erase_try(1'b0);
        end
        1: halt_try(0);
        2: begin
          halt_try(1);
          @(posedge clk);
          halt_exit <= 1'b1;
          @(posedge clk);
          halt_exit <= 1'b0;
          phase_len(256, "halt exit phase");
        end
        3: erase_try(1'b1);
        default: begin
          halt_try(0);
          @(posedge clk);
          bus(1'b1, `ADDR_CTRL, 32'h0000_0001);
          @(negedge clk);
          chk("soft watchdog", 1, {31'h0, watchdog_enable});
          @(posedge clk);
          bus(1'b0, `ADDR_CTRL, 0);
          chk("ctrl readback", 1, rd);
          bus(1'b0, `ADDR_STATE, 0);
          chk("state", 32'h0000_0004, rd);
          halt_try(1);
        end
      endcase
      $display("config %0d done, mismatches so far %0d", k, errors);
    end
    tally_and_finish();
  end
endmodule // option_byte_config_decoder_tb

// *** dv/prog_tool_model.sv ***
// Purpose: Programming tool side: option store contents and erase request pin
// Assumes: Wanted bytes are changed only between checks; store is static meanwhile
// Notes:   Illegal combinations are cleaned up before they reach the store
`timescale 1ns/1ps
module prog_tool_model (
  input  wire logic       clk,
  input  wire logic [7:0] want_byte0,
  input  wire logic [7:0] want_byte1,
  input  wire logic       erase_cmd,
  output logic [7:0]      store_byte0,
  output logic [7:0]      store_byte1,
  output logic            erase_req_pin
);
  logic is_reso;
  logic dbl_ok;
  // Store reached only by this tool, never by the processor
  always_comb begin
    is_reso     = (want_byte1[5:4] == 2'h0);
    dbl_ok      = is_reso && (want_byte1[3:1] == 3'h1);
    store_byte0 = want_byte0 | 8'h24;
    if (want_byte0[4:3] != 2'h3) begin
      store_byte0[0] = 1'b1;
    end
    store_byte1 = want_byte1;
    if (is_reso) begin
      store_byte1[6] = 1'b0;
    end
    if (!dbl_ok) begin
      store_byte1[0] = 1'b1;
    end
  end
  // Request is a level, held until the tool drops it
  always_ff @(posedge clk) begin
    erase_req_pin <= erase_cmd;
  end
endmodule // prog_tool_model
